// *** bench/mmd_core_model.sv ***
// Core-side requester model that drives the decoder request port
`timescale 1ns/1ps
module mmd_core_model (
   input  wire logic                mclk,
   input  wire logic                resp_valid,
   output logic                     req,
   output mmd_pkg::mmd_port_t       req_port,
   output logic                     req_fetch,
   output logic                     req_write,
   output logic [1:0]               req_size,
   output logic [31:0]              req_addr,
   output logic [31:0]              req_wdata
);
   initial begin
      req = 1'b0;
      req_port = mmd_pkg::MMD_PORT_SYS;
      req_fetch = 1'b0;
      req_write = 1'b0;
      req_size = mmd_pkg::SIZE_WORD;
      req_addr = 32'h0;
      req_wdata = 32'h0;
   end

   // Entered just after an edge; taken at the next edge
   task automatic access(input mmd_pkg::mmd_port_t p, input logic f, input logic w,
                         input logic [1:0] s, input logic [31:0] a, input logic [31:0] d);
      int n;
      req = 1'b1;
      req_port = p;
      req_fetch = f;
      req_write = w;
      req_size = s;
      req_addr = a;
      req_wdata = d;
      @(posedge mclk);
      #1;
      // Fast answers keep req up so the next access follows back to back
      if (resp_valid !== 1'b1) begin
         req = 1'b0;
         n = 0;
         while (resp_valid !== 1'b1 && n < 20) begin
            @(posedge mclk);
            #1;
            n++;
         end
      end
   endtask : access

   task automatic release_bus;
      req = 1'b0;
      @(posedge mclk);
      #1;
   endtask : release_bus
endmodule : mmd_core_model

// *** bench/tb.sv ***
// Self-checking testbench for the memory map decoder
`timescale 1ns/1ps
module tb;
   typedef struct packed {
      logic                 err;
      logic [31:0]          rdata;
      mmd_pkg::mmd_region_t region;
      mmd_pkg::mmd_target_t target;
      logic                 xmc;
      logic                 clk;
   } mmd_exp_t;

   localparam mmd_pkg::mmd_port_t   IC = mmd_pkg::MMD_PORT_INSTR;
   localparam mmd_pkg::mmd_port_t   DC = mmd_pkg::MMD_PORT_DATA;
   localparam mmd_pkg::mmd_port_t   SY = mmd_pkg::MMD_PORT_SYS;
   localparam mmd_pkg::mmd_region_t RC = mmd_pkg::MMD_REG_CODE;
   localparam mmd_pkg::mmd_region_t RS = mmd_pkg::MMD_REG_SRAM;
   localparam mmd_pkg::mmd_region_t RP = mmd_pkg::MMD_REG_PERI;
   localparam mmd_pkg::mmd_region_t RX = mmd_pkg::MMD_REG_XRAM;
   localparam mmd_pkg::mmd_region_t RE = mmd_pkg::MMD_REG_XPERI;
   localparam mmd_pkg::mmd_region_t RI = mmd_pkg::MMD_REG_IPERI;
   localparam mmd_pkg::mmd_target_t TN = mmd_pkg::MMD_TGT_NONE;
   localparam mmd_pkg::mmd_target_t TS = mmd_pkg::MMD_TGT_SYS;
   localparam mmd_pkg::mmd_target_t TP = mmd_pkg::MMD_TGT_PRIV;
   localparam mmd_pkg::mmd_target_t TC = mmd_pkg::MMD_TGT_CODE;
   localparam logic [1:0]           W = mmd_pkg::SIZE_WORD;

   logic                 mclk = 1'b0;
   logic                 rst = 1'b1;
   logic                 req, req_fetch, req_write, busy, resp_valid, resp_err;
   logic                 resp_xmc, resp_clk;
   mmd_pkg::mmd_port_t   req_port;
   logic [1:0]           req_size;
   logic [31:0]          req_addr, req_wdata, resp_rdata;
   mmd_pkg::mmd_region_t resp_region;
   mmd_pkg::mmd_target_t resp_target;
   mmd_exp_t             exp_q[$];
   mmd_exp_t             mon_e;
   int                   num_errors = 0;
   int                   samples_checked = 0;
   int                   cycles = 0;
   logic [31:0]          seed = 32'h0001_47ef;
   logic [31:0]          wa, wb, wc, m;
   logic [15:0]          h;
   logic [4:0]           b;

   always #50 mclk = ~mclk;

   mmd_core_model core (.mclk(mclk), .resp_valid(resp_valid), .req(req), .req_port(req_port),
      .req_fetch(req_fetch), .req_write(req_write), .req_size(req_size), .req_addr(req_addr),
      .req_wdata(req_wdata));

   mmd_top DUT (.mclk(mclk), .rst(rst), .req(req), .req_port(req_port), .req_fetch(req_fetch),
      .req_write(req_write), .req_size(req_size), .req_addr(req_addr), .req_wdata(req_wdata),
      .busy(busy), .resp_valid(resp_valid), .resp_err(resp_err), .resp_rdata(resp_rdata),
      .resp_region(resp_region), .resp_target(resp_target), .resp_xmc(resp_xmc),
      .resp_clk(resp_clk));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic end_of_test;
      $display("errors %0d comparisons %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test

   // Word read that the RAM does not serve, answered with zero data
   task automatic dec(input mmd_pkg::mmd_port_t p, input logic f, input logic [31:0] a,
      input logic e, input mmd_pkg::mmd_region_t r, input mmd_pkg::mmd_target_t t,
      input logic em, input logic ck);
      exp_q.push_back('{e, 32'h0, r, t, em, ck});
      core.access(p, f, 1'b0, W, a, 32'h0);
   endtask : dec

   task automatic mem(input mmd_pkg::mmd_port_t p, input logic f, input logic w,
      input logic [1:0] s, input logic [31:0] a, input logic [31:0] d, input logic [31:0] rd,
      input mmd_pkg::mmd_region_t r, input mmd_pkg::mmd_target_t t);
      exp_q.push_back('{1'b0, rd, r, t, 1'b0, 1'b0});
      core.access(p, f, w, s, a, d);
   endtask : mem

   always @(posedge mclk) begin
      if (!rst && resp_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            num_errors++;
            $display("CHECK FAILED resp_valid expected none seen 1");
         end else begin
            mon_e = exp_q.pop_front();
            check("resp_err", {31'h0, resp_err}, {31'h0, mon_e.err});
            check("resp_rdata", resp_rdata, mon_e.rdata);
            check("resp_region", {29'h0, resp_region}, {29'h0, mon_e.region});
            check("resp_target", {30'h0, resp_target}, {30'h0, mon_e.target});
            check("resp_xmc", {31'h0, resp_xmc}, {31'h0, mon_e.xmc});
            check("resp_clk", {31'h0, resp_clk}, {31'h0, mon_e.clk});
         end
      end
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles >= 3000) begin
         num_errors++;
         $display("CHECK FAILED run length expected under 3000 seen %0d", cycles);
         end_of_test();
      end
   end

   initial begin
      repeat (5) @(posedge mclk);
      #1;
      rst = 1'b0;
      check("busy", {31'h0, busy}, 32'h0);
      check("resp_valid", {31'h0, resp_valid}, 32'h0);
      // Region decode, back to back on every cycle
      dec(IC, 1, 32'h0000_0000, 0, RC, TC, 0, 0);
      dec(DC, 0, 32'h1fff_7ffc, 0, RC, TC, 0, 0);
      dec(DC, 0, 32'h4000_0000, 1, RP, TN, 0, 0);
      dec(IC, 1, 32'h2000_0000, 1, RS, TN, 0, 0);
      dec(SY, 0, 32'h4000_0000, 0, RP, TS, 0, 0);
      dec(SY, 0, 32'h5fff_ffff, 0, RP, TS, 0, 0);
      dec(SY, 0, 32'h6000_0000, 0, RX, TS, 0, 0);
      dec(SY, 0, 32'h9fff_ffff, 0, RX, TS, 0, 0);
      dec(SY, 0, 32'ha000_0000, 0, RE, TS, 0, 0);
      dec(SY, 0, 32'hdfff_ffff, 0, RE, TS, 0, 0);
      dec(SY, 0, 32'h4000_53ff, 0, RP, TS, 0, 0);
      dec(SY, 0, 32'h4000_5400, 0, RP, TS, 1, 0);
      dec(SY, 0, 32'h4000_54ff, 0, RP, TS, 1, 0);
      dec(SY, 0, 32'h4000_5500, 0, RP, TS, 0, 0);
      dec(SY, 0, 32'h4000_3fff, 0, RP, TS, 0, 0);
      dec(SY, 0, 32'h4000_4000, 0, RP, TS, 0, 1);
      dec(SY, 0, 32'h4000_42ff, 0, RP, TS, 0, 1);
      dec(SY, 0, 32'h4000_4300, 0, RP, TS, 0, 0);
      dec(SY, 0, 32'he000_0000, 0, RI, TP, 0, 0);
      dec(SY, 0, 32'he00f_ffff, 0, RI, TP, 0, 0);
      dec(SY, 0, 32'he010_0000, 0, RI, TS, 0, 0);
      dec(SY, 0, 32'hffff_ffff, 0, RI, TS, 0, 0);
      dec(SY, 1, 32'h6000_0000, 1, RX, TN, 0, 0);
      dec(SY, 1, 32'he000_0000, 1, RI, TN, 0, 0);
      // SRAM in both halves, fetches and unaligned pairs
      seed = lfsr(seed);
      wa = seed;
      seed = lfsr(seed);
      wb = seed;
      seed = lfsr(seed);
      wc = seed;
      h = wc[23:8];
      mem(SY, 0, 1, W, 32'h2000_0000, wa, 32'h0, RS, TS);
      mem(SY, 0, 1, W, 32'h2000_0004, wb, 32'h0, RS, TS);
      mem(SY, 0, 0, W, 32'h2000_0000, 32'h0, wa, RS, TS);
      mem(SY, 0, 0, W, 32'h2000_0002, 32'h0, {wb[15:0], wa[31:16]}, RS, TS);
      mem(SY, 1, 0, W, 32'h2000_0004, 32'h0, wb, RS, TS);
      mem(SY, 0, 1, W, 32'h2000_7ffc, wc, 32'h0, RS, TS);
      mem(SY, 0, 0, W, 32'h2000_7ffc, 32'h0, wc, RS, TS);
      mem(DC, 0, 1, W, 32'h1fff_8000, wc, 32'h0, RC, TC);
      mem(IC, 1, 0, W, 32'h1fff_8000, 32'h0, wc, RC, TC);
      mem(DC, 0, 1, W, 32'h1fff_fffc, wb, 32'h0, RC, TC);
      mem(DC, 0, 0, W, 32'h1fff_fffc, 32'h0, wb, RC, TC);
      mem(SY, 0, 1, W, 32'h2000_0010, wa, 32'h0, RS, TS);
      mem(SY, 0, 1, W, 32'h2000_0014, wb, 32'h0, RS, TS);
      mem(SY, 0, 1, mmd_pkg::SIZE_HALF, 32'h2000_0013, {16'h0, h}, 32'h0, RS, TS);
      mem(SY, 0, 0, W, 32'h2000_0010, 32'h0, {h[7:0], wa[23:0]}, RS, TS);
      mem(SY, 0, 0, W, 32'h2000_0014, 32'h0, {wb[31:8], h[15:8]}, RS, TS);
      // Bit-band alias: other data bits must be ignored
      mem(SY, 0, 1, W, 32'h2200_000c, 32'hffff_fff1, 32'h0, RS, TS);
      mem(SY, 0, 0, W, 32'h2000_0000, 32'h0, wa | 32'h8, RS, TS);
      m = wc;
      mem(SY, 0, 1, W, 32'h2000_0040, m, 32'h0, RS, TS);
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         b = seed[10:6];
         m[b] = seed[0];
         mem(SY, 0, 1, W, 32'h2200_0800 + {25'h0, b, 2'h0}, seed, 32'h0, RS, TS);
         mem(SY, 0, 0, W, 32'h2200_0800 + {25'h0, b, 2'h0}, 32'h0, {31'h0, m[b]}, RS, TS);
      end
      mem(SY, 0, 0, W, 32'h2000_0040, 32'h0, m, RS, TS);
      dec(SY, 0, 32'h2210_0000, 1, RS, TS, 0, 0);
      core.release_bus();
      repeat (5) @(posedge mclk);
      check("pending answers", exp_q.size(), 32'h0);
      end_of_test();
   end
endmodule : tb

// *** hdl/mmd_pkg.sv ***
// Constants for the memory map address decoder
package mmd_pkg;
   localparam logic [31:0] CODE_BASE     = 32'h0000_0000;
   localparam logic [31:0] CODE_END      = 32'h1fff_ffff;
   localparam logic [31:0] SRAM_BASE     = 32'h2000_0000;
   localparam logic [31:0] SRAM_END      = 32'h3fff_ffff;
   localparam logic [31:0] BB_BASE       = 32'h2000_0000;
   localparam logic [31:0] BB_END        = 32'h200f_ffff;
   localparam logic [31:0] ALIAS_BASE    = 32'h2200_0000;
   localparam logic [31:0] ALIAS_END     = 32'h23ff_ffff;
   localparam logic [31:0] PERI_BASE     = 32'h4000_0000;
   localparam logic [31:0] PERI_END      = 32'h5fff_ffff;
   localparam logic [31:0] XRAM_BASE     = 32'h6000_0000;
   localparam logic [31:0] XRAM_END      = 32'h9fff_ffff;
   localparam logic [31:0] XPERI_BASE    = 32'ha000_0000;
   localparam logic [31:0] XPERI_END     = 32'hdfff_ffff;
   localparam logic [31:0] IPERI_BASE    = 32'he000_0000;
   localparam logic [31:0] IPERI_END     = 32'hffff_ffff;
   localparam logic [31:0] PRIV_BASE     = 32'he000_0000;
   localparam logic [31:0] PRIV_END      = 32'he00f_ffff;
   localparam logic [31:0] CSRAM_BASE    = 32'h1fff_8000;
   localparam logic [31:0] CSRAM_END     = 32'h1fff_ffff;
   localparam logic [31:0] SSRAM_BASE    = 32'h2000_0000;
   localparam logic [31:0] SSRAM_END     = 32'h2000_7fff;
   localparam logic [31:0] XMC_BASE      = 32'h4000_5400;
   localparam logic [31:0] XMC_END       = 32'h4000_54ff;
   localparam logic [31:0] CLK_BASE      = 32'h4000_4000;
   localparam logic [31:0] CLK_END       = 32'h4000_42ff;
   // Combined 64K SRAM, word indexed
   localparam int          SRAM_WORDS    = 16384;
   localparam int          SRAM_AW       = 14;
   localparam logic [31:0] RAM_LO        = 32'h1fff_8000;
   localparam logic [31:0] RAM_HI        = 32'h2000_7fff;

   typedef enum logic [2:0] {
      MMD_REG_NONE  = 3'b000,
      MMD_REG_CODE  = 3'b001,
      MMD_REG_SRAM  = 3'b010,
      MMD_REG_PERI  = 3'b011,
      MMD_REG_XRAM  = 3'b100,
      MMD_REG_XPERI = 3'b101,
      MMD_REG_IPERI = 3'b110
   } mmd_region_t;

   typedef enum logic [1:0] {
      MMD_PORT_INSTR = 2'b00,
      MMD_PORT_DATA  = 2'b01,
      MMD_PORT_SYS   = 2'b10
   } mmd_port_t;

   typedef enum logic [1:0] {
      MMD_TGT_NONE = 2'b00,
      MMD_TGT_SYS  = 2'b01,
      MMD_TGT_PRIV = 2'b10,
      MMD_TGT_CODE = 2'b11
   } mmd_target_t;

   typedef enum logic [1:0] {
      MMD_ST_IDLE = 2'b00,
      MMD_ST_RD   = 2'b01,
      MMD_ST_WR   = 2'b10,
      MMD_ST_RESP = 2'b11
   } mmd_state_t;

   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
endpackage : mmd_pkg

// *** hdl/mmd_region_dec.sv ***
// Region and target decode for one address
`timescale 1ns/1ps
module mmd_region_dec (
   input  wire logic [31:0]          addr,
   input  wire mmd_pkg::mmd_port_t   port,
   input  wire logic                 is_fetch,
   output mmd_pkg::mmd_region_t      region,
   output mmd_pkg::mmd_target_t      target,
   output logic                      in_ram,
   output logic                      in_alias,
   output logic                      sub_xmc,
   output logic                      sub_clk
);
   function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo,
                                   input logic [31:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction : in_rng

   wire logic r_code  = in_rng(addr, mmd_pkg::CODE_BASE, mmd_pkg::CODE_END);
   wire logic r_sram  = in_rng(addr, mmd_pkg::SRAM_BASE, mmd_pkg::SRAM_END);
   wire logic r_peri  = in_rng(addr, mmd_pkg::PERI_BASE, mmd_pkg::PERI_END);
   wire logic r_xram  = in_rng(addr, mmd_pkg::XRAM_BASE, mmd_pkg::XRAM_END);
   wire logic r_xperi = in_rng(addr, mmd_pkg::XPERI_BASE, mmd_pkg::XPERI_END);
   wire logic r_iperi = in_rng(addr, mmd_pkg::IPERI_BASE, mmd_pkg::IPERI_END);
   wire logic r_priv  = in_rng(addr, mmd_pkg::PRIV_BASE, mmd_pkg::PRIV_END);
   wire logic code_bus = (port != mmd_pkg::MMD_PORT_SYS);
   // Fetches on the system bus only reach the SRAM region
   wire logic sys_ok  = (r_sram || r_peri || r_xram || r_xperi || (r_iperi && !r_priv))
                        && (!is_fetch || r_sram);

   assign region = r_code  ? mmd_pkg::MMD_REG_CODE  :
                   r_sram  ? mmd_pkg::MMD_REG_SRAM  :
                   r_peri  ? mmd_pkg::MMD_REG_PERI  :
                   r_xram  ? mmd_pkg::MMD_REG_XRAM  :
                   r_xperi ? mmd_pkg::MMD_REG_XPERI : mmd_pkg::MMD_REG_IPERI;
   assign target = code_bus ? (r_code ? mmd_pkg::MMD_TGT_CODE : mmd_pkg::MMD_TGT_NONE) :
                   (r_priv && !is_fetch) ? mmd_pkg::MMD_TGT_PRIV :
                   sys_ok ? mmd_pkg::MMD_TGT_SYS : mmd_pkg::MMD_TGT_NONE;
   assign in_ram   = in_rng(addr, mmd_pkg::RAM_LO, mmd_pkg::RAM_HI);
   assign in_alias = in_rng(addr, mmd_pkg::ALIAS_BASE, mmd_pkg::ALIAS_END);
   assign sub_xmc  = in_rng(addr, mmd_pkg::XMC_BASE, mmd_pkg::XMC_END);
   assign sub_clk  = in_rng(addr, mmd_pkg::CLK_BASE, mmd_pkg::CLK_END);
endmodule : mmd_region_dec

// *** hdl/mmd_top.sv ***
// Memory map decoder and router with on-chip SRAM and bit-band alias
`timescale 1ns/1ps
module mmd_top (
   input  wire logic                mclk,
   input  wire logic                rst,
   input  wire logic                req,
   input  wire mmd_pkg::mmd_port_t  req_port,
   input  wire logic                req_fetch,
   input  wire logic                req_write,
   input  wire logic [1:0]          req_size,
   input  wire logic [31:0]         req_addr,
   input  wire logic [31:0]         req_wdata,
   output logic                     busy,
   output logic                     resp_valid,
   output logic                     resp_err,
   output logic [31:0]              resp_rdata,
   output mmd_pkg::mmd_region_t     resp_region,
   output mmd_pkg::mmd_target_t     resp_target,
   output logic                     resp_xmc,
   output logic                     resp_clk
);
   mmd_pkg::mmd_region_t   dec_region;
   mmd_pkg::mmd_target_t   dec_target;
   logic                   dec_ram;
   logic                   dec_alias;
   logic                   dec_xmc;
   logic                   dec_clk;

   mmd_region_dec u_dec (
      .addr     (req_addr),
      .port     (req_port),
      .is_fetch (req_fetch),
      .region   (dec_region),
      .target   (dec_target),
      .in_ram   (dec_ram),
      .in_alias (dec_alias),
      .sub_xmc  (dec_xmc),
      .sub_clk  (dec_clk)
   );

   logic [31:0]            mem [mmd_pkg::SRAM_WORDS];
   mmd_pkg::mmd_state_t    state;
   logic [31:0]            a_addr;
   logic [31:0]            a_wdata;
   logic [1:0]             a_size;
   logic                   a_alias;
   logic                   a_write;
   logic                   a_second;
   logic [31:0]            lo_word;

   function automatic logic [mmd_pkg::SRAM_AW-1:0] widx(input logic [31:0] a);
      logic [31:0] off;
      off  = a - mmd_pkg::RAM_LO;
      widx = off[mmd_pkg::SRAM_AW+1:2];
   endfunction : widx

   // Alias word n maps to bit n%32 of word n/32 above the bit-band base
   wire logic [31:0] alias_off = a_addr - mmd_pkg::ALIAS_BASE;
   wire logic [31:0] bb_addr   = mmd_pkg::BB_BASE + {12'h000, alias_off[24:7], 2'b00};
   wire logic [4:0]  bb_bit    = alias_off[6:2];
   wire logic        bb_in_ram = (bb_addr <= mmd_pkg::RAM_HI);
   wire logic [1:0]  lane      = a_addr[1:0];
   wire logic [2:0]  nbytes    = (a_size == mmd_pkg::SIZE_WORD) ? 3'h4 :
                                 (a_size == mmd_pkg::SIZE_HALF) ? 3'h2 : 3'h1;
   wire logic        spans     = ({1'b0, lane} + nbytes) > 3'h4;
   wire logic [31:0] hi_addr   = {a_addr[31:2], 2'b00} + 32'h0000_0004;
   wire logic [31:0] cur_addr  = a_alias ? bb_addr : (a_second ? hi_addr : a_addr);
   wire logic        cur_ok    = (cur_addr >= mmd_pkg::RAM_LO) && (cur_addr <= mmd_pkg::RAM_HI);
   wire logic [mmd_pkg::SRAM_AW-1:0] cur_idx = widx(cur_addr);
   wire logic [31:0] cur_word  = mem[cur_idx];
   wire logic [3:0]  lane_mask = (a_size == mmd_pkg::SIZE_WORD) ? 4'hf :
                                 (a_size == mmd_pkg::SIZE_HALF) ? 4'h3 : 4'h1;
   wire logic [7:0]  mask8     = {4'h0, lane_mask} << lane;
   wire logic [63:0] wdata64   = {32'h0000_0000, a_wdata} << {lane, 3'h0};
   wire logic [3:0]  be        = a_second ? mask8[7:4] : mask8[3:0];
   wire logic [31:0] wsel      = a_second ? wdata64[63:32] : wdata64[31:0];
   wire logic [31:0] bmask     = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   wire logic [31:0] bit_mask  = 32'h0000_0001 << bb_bit;
   wire logic [31:0] next_word = a_alias
                                 ? ((cur_word & ~bit_mask) | (a_wdata[0] ? bit_mask : 32'h0))
                                 : ((cur_word & ~bmask) | (wsel & bmask));
   wire logic [63:0] rd64      = a_second ? {cur_word, lo_word} : {32'h0, cur_word};
   wire logic [63:0] rd_sh     = rd64 >> {lane, 3'h0};
   wire logic [31:0] rd_mask   = (a_size == mmd_pkg::SIZE_WORD) ? 32'hffff_ffff :
                                 (a_size == mmd_pkg::SIZE_HALF) ? 32'h0000_ffff : 32'h0000_00ff;
   wire logic [31:0] next_rdata = a_alias ? {31'h0, cur_word[bb_bit]}
                                          : (rd_sh[31:0] & rd_mask);
   // Accesses to RAM that are accepted by the target decode
   wire logic        req_ram   = (dec_target != mmd_pkg::MMD_TGT_NONE) && (dec_ram || dec_alias);
   wire logic        req_bad   = (dec_target == mmd_pkg::MMD_TGT_NONE);

   // Off-RAM targets answer at once with zero data; no slave model lives here
   always_ff @(posedge mclk) begin
      if (rst) begin
         state       <= mmd_pkg::MMD_ST_IDLE;
         busy        <= 1'b0;
         resp_valid  <= 1'b0;
         resp_err    <= 1'b0;
         resp_rdata  <= 32'h0000_0000;
         resp_region <= mmd_pkg::MMD_REG_NONE;
         resp_target <= mmd_pkg::MMD_TGT_NONE;
         resp_xmc    <= 1'b0;
         resp_clk    <= 1'b0;
         a_addr      <= 32'h0000_0000;
         a_wdata     <= 32'h0000_0000;
         a_size      <= mmd_pkg::SIZE_BYTE;
         a_alias     <= 1'b0;
         a_write     <= 1'b0;
         a_second    <= 1'b0;
         lo_word     <= 32'h0000_0000;
      end else begin
         resp_valid <= 1'b0;
         case (state)
            mmd_pkg::MMD_ST_IDLE: begin
               if (req) begin
                  resp_region <= dec_region;
                  resp_target <= dec_target;
                  resp_xmc    <= dec_xmc;
                  resp_clk    <= dec_clk;
                  a_addr      <= req_addr;
                  a_wdata     <= req_wdata;
                  a_size      <= req_size;
                  a_alias     <= dec_alias;
                  a_write     <= req_write;
                  a_second    <= 1'b0;
                  if (req_ram) begin
                     busy  <= 1'b1;
                     state <= req_write ? mmd_pkg::MMD_ST_WR : mmd_pkg::MMD_ST_RD;
                  end else begin
                     resp_valid <= 1'b1;
                     resp_err   <= req_bad;
                     resp_rdata <= 32'h0000_0000;
                  end
               end
            end
            mmd_pkg::MMD_ST_RD, mmd_pkg::MMD_ST_WR: begin
               if (!cur_ok || (a_alias && !bb_in_ram)) begin
                  // Alias of unpopulated bit-band word, or spill past the SRAM
                  resp_err   <= 1'b1;
                  resp_rdata <= 32'h0000_0000;
                  state      <= mmd_pkg::MMD_ST_RESP;
               end else if (!a_alias && spans && !a_second) begin
                  lo_word  <= cur_word;
                  a_second <= 1'b1;
               end else begin
                  resp_err   <= 1'b0;
                  resp_rdata <= a_write ? 32'h0000_0000 : next_rdata;
                  state      <= mmd_pkg::MMD_ST_RESP;
               end
            end
            mmd_pkg::MMD_ST_RESP: begin
               resp_valid <= 1'b1;
               busy       <= 1'b0;
               state      <= mmd_pkg::MMD_ST_IDLE;
            end
            default: begin
               state <= mmd_pkg::MMD_ST_IDLE;
            end
         endcase
      end
   end

   // Read-modify-write in one cycle keeps alias writes atomic
   wire logic do_wr = (state == mmd_pkg::MMD_ST_WR) && cur_ok && !(a_alias && !bb_in_ram);
   always_ff @(posedge mclk) begin
      if (do_wr) begin
         mem[cur_idx] <= next_word;
      end
   end

   logic idle_q;
   always_ff @(posedge mclk) begin
      idle_q <= rst ? 1'b1 : (state == mmd_pkg::MMD_ST_IDLE);
   end

   property p_bad_err;
      @(posedge mclk) disable iff (rst)
         (state == mmd_pkg::MMD_ST_IDLE && req && req_bad) |=> resp_valid && resp_err;
   endproperty
   a_bad_err: assert property (p_bad_err) else $error("undecoded access not erred");

   property p_code_bus;
      @(posedge mclk) disable iff (rst)
         (req && req_port != mmd_pkg::MMD_PORT_SYS && req_addr > mmd_pkg::CODE_END)
         |-> dec_target == mmd_pkg::MMD_TGT_NONE;
   endproperty
   a_code_bus: assert property (p_code_bus) else $error("code bus left code region");

   property p_priv;
      @(posedge mclk) disable iff (rst)
         (req && req_port == mmd_pkg::MMD_PORT_SYS && !req_fetch && req_addr >= mmd_pkg::PRIV_BASE
          && req_addr <= mmd_pkg::PRIV_END) |-> dec_target == mmd_pkg::MMD_TGT_PRIV;
   endproperty
   a_priv: assert property (p_priv) else $error("private range not on private bus");

   property p_fetch;
      @(posedge mclk) disable iff (rst)
         (req && req_port == mmd_pkg::MMD_PORT_SYS && req_fetch && dec_target != mmd_pkg::MMD_TGT_NONE)
         |-> dec_region == mmd_pkg::MMD_REG_SRAM;
   endproperty
   a_fetch: assert property (p_fetch) else $error("system fetch outside SRAM");

   property p_alias_rd;
      @(posedge mclk) disable iff (rst)
         (state == mmd_pkg::MMD_ST_RESP && a_alias && !a_write) |=> resp_rdata[31:1] == 31'h0;
   endproperty
   a_alias_rd: assert property (p_alias_rd) else $error("alias read not 0 or 1");

   property p_alias_wr;
      @(posedge mclk) disable iff (rst)
         (do_wr && a_alias) |=> (mem[$past(cur_idx)] & ~$past(bit_mask))
                                == ($past(cur_word) & ~$past(bit_mask));
   endproperty
   a_alias_wr: assert property (p_alias_wr) else $error("alias write touched other bits");

   property p_ram_lat;
      @(posedge mclk) disable iff (rst)
         (idle_q && state == mmd_pkg::MMD_ST_RD) |-> ##[1:3] resp_valid;
   endproperty
   a_ram_lat: assert property (p_ram_lat) else $error("SRAM access did not answer");

   property p_sub;
      @(posedge mclk) disable iff (rst)
         (state == mmd_pkg::MMD_ST_IDLE && req && req_addr == mmd_pkg::XMC_BASE)
         |=> resp_xmc && !resp_clk && resp_region == mmd_pkg::MMD_REG_PERI;
   endproperty
   a_sub: assert property (p_sub) else $error("sub-range decode wrong");
endmodule : mmd_top
